// file: rtl/ipm_ctrl.sv
// Interrupt arbiter, vector source and idle/stop mode control.
// Assumes clk_in is always on; clock enables gate the stopped domains.
// Function
// - Idle request sleeps CPU, peripherals keep running
// - Gate setting stops timers, ADC, UART in idle
// - Reset or enabled interrupt ends idle
// - Stop request bit enters stop mode
// - Stop halts all clocks except enabled watchdog
// - Only reset or pin wake leaves stop
// - Stop ignored while enabled ext pin low
// - Eleven sources, own enables, four levels
// - Events set flags regardless of interrupt enables; port change only on wake-enabled pins
// - Vectors 0003 to 005B, step eight
// - Shared vectors OR their source flags
// - Equal level waits, higher level preempts
// - Global enable zero blocks all interrupts
// - Ext pin enable also enables stop wake
// - Per-pin port wake enable, reset zero
// - Two-bit priority from high, low bits
// - Enable bits at documented positions
// - Priority bits at documented positions
// - Pin flags clear when CPU vectors
// - After stop wake, next instruction first
// - After idle wake, routine entered immediately
//
// The address-and-strobe port is this design's own decision.
`default_nettype none

module ipm_ctrl #(
    parameter logic [7:0] STOP_RESUME_CYCLES = ipm_pkg::STOP_RESUME_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Peripheral events and pins
    input wire ipm_pkg::ipm_periph_ev_t periph_ev_in,
    input wire logic ext_pin_zero_in,
    input wire logic ext_pin_one_in,
    input wire logic ext_pin_two_in,
    input wire logic [7:0] port1_pins_in,
    // Clock control inputs
    input wire logic idle_periph_clock_gate_in,
    input wire logic wdt_enable_in,
    // CPU vector handshake
    input wire logic irq_ack_in,
    input wire logic irq_return_in,
    output logic irq_req_out,
    output logic [15:0] irq_vector_out,
    output logic [1:0] irq_level_out,
    // Clock enables
    output logic cpu_clk_en_out,
    output logic periph_clk_en_out,
    output logic sys_clk_en_out,
    output logic wdt_clk_en_out
);
    ipm_pkg::ipm_state_t s_r, s_nxt;
    logic [10:0] src_flag, src_en, src_req;
    logic [21:0] src_lvl;
    logic [1:0] best_lvl;
    logic [3:0] best_idx;
    logic [2:0] active_top;
    logic found, grant, any_req, pin_low, pin_wake, p1_change;
    logic [2:0] ext_en, ext_fall;
    logic [7:0] p1_diff;
    logic [15:0] set_v, ack_clr;

    // Vector of a source index, skipping the reserved slot
    function automatic logic [15:0] vec_of(input logic [3:0] idx);
        logic [3:0] slot;
        slot = (idx >= 4'(ipm_pkg::RESERVED_SLOT)) ? idx + 4'h1 : idx;
        return ipm_pkg::VEC_BASE + ipm_pkg::VEC_STEP * {12'h000, slot};
    endfunction

    // Highest active level, plus a valid bit on top
    function automatic logic [2:0] top_of(input logic [3:0] m);
        if (m[3]) return 3'h7;
        else if (m[2]) return 3'h6;
        else if (m[1]) return 3'h5;
        else if (m[0]) return 3'h4;
        else return 3'h0;
    endfunction

    // Source view: shared vectors OR their flags
    always_comb begin
        src_flag[0] = s_r.flags.ext0_edge_flag;
        src_flag[1] = s_r.flags.timer0_overflow_flag;
        src_flag[2] = s_r.flags.ext1_edge_flag;
        src_flag[3] = s_r.flags.timer1_overflow_flag;
        src_flag[4] = s_r.flags.uart_rx_flag | s_r.flags.uart_tx_flag;
        src_flag[5] = s_r.flags.timer2_overflow_flag | s_r.flags.timer2_external_flag;
        src_flag[6] = s_r.flags.timer3_overflow_flag;
        src_flag[7] = s_r.flags.port_change_flag;
        src_flag[8] = s_r.flags.ext2_edge_flag;
        src_flag[9] = s_r.flags.adc_done_flag | s_r.flags.touch_done_flag;
        src_flag[10] = s_r.flags.spi_done_flag | s_r.flags.spi_collision_flag
            | s_r.flags.spi_mode_fault_flag;
    end

    // Enables and priorities share one bit layout per register pair
    assign src_en = {s_r.en_s, s_r.en_m};
    assign src_req = src_flag & src_en & {11{s_r.global_int_enable}};
    assign any_req = |src_req;

    // Level per source, high bit over low bit
    generate
        for (genvar g = 0; g < ipm_pkg::NUM_SRC; g++) begin : g_lvl
            if (g < ipm_pkg::RESERVED_SLOT) begin : g_main
                assign src_lvl[2*g+1 -: 2] = {s_r.ph[g], s_r.pl[g]};
            end else begin : g_sec
                assign src_lvl[2*g+1 -: 2] = {s_r.p2h[g-6], s_r.p2l[g-6]};
            end
        end
    endgenerate

    // Highest level; downward scan leaves lowest index on ties
    always_comb begin
        found = 1'b0;
        best_lvl = 2'h0;
        best_idx = 4'h0;
        for (int i = ipm_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (src_req[i] && (!found || src_lvl[2*i+1 -: 2] >= best_lvl)) begin
                found = 1'b1;
                best_lvl = src_lvl[2*i+1 -: 2];
                best_idx = 4'(i);
            end
        end
    end

    // Highest level in service, valid bit on top
    assign active_top = top_of(s_r.insvc);
    // Preempt only a strictly lower running level
    assign grant = found && (!active_top[2] || best_lvl > active_top[1:0]);

    // Pin conditions after synchronising
    assign ext_en = {s_r.en_s[2], s_r.en_m[2], s_r.en_m[0]};
    assign pin_low = |(~s_r.ext_s2 & ext_en);
    assign ext_fall = s_r.ext_d & ~s_r.ext_s2;
    assign p1_diff = (s_r.p1_d ^ s_r.p1_s2) & s_r.wake;
    assign p1_change = |p1_diff;
    assign pin_wake = pin_low | |(ext_fall & ext_en) | p1_change;

    // Flags set by events; pin flags auto-clear on vector fetch
    always_comb begin
        set_v = {periph_ev_in.spi_mode_fault_flag, periph_ev_in.spi_collision_flag,
            periph_ev_in.spi_done_flag, periph_ev_in.touch_done_flag,
            periph_ev_in.adc_done_flag, ext_fall[2], p1_change,
            periph_ev_in.timer3_overflow_flag, periph_ev_in.timer2_external_flag,
            periph_ev_in.timer2_overflow_flag, periph_ev_in.uart_tx_flag,
            periph_ev_in.uart_rx_flag, periph_ev_in.timer1_overflow_flag, ext_fall[1],
            periph_ev_in.timer0_overflow_flag, ext_fall[0]};
        ack_clr = 16'h0000;
        if (irq_ack_in) begin
            if (s_r.vec == vec_of(4'(ipm_pkg::SRC_EXT0))) ack_clr[0] = 1'b1;
            if (s_r.vec == vec_of(4'(ipm_pkg::SRC_EXT1))) ack_clr[2] = 1'b1;
            if (s_r.vec == vec_of(4'(ipm_pkg::SRC_P1))) ack_clr[9] = 1'b1;
            if (s_r.vec == vec_of(4'(ipm_pkg::SRC_EXT2))) ack_clr[10] = 1'b1;
        end
    end

    // Next state: one process for registers, modes and arbitration
    always_comb begin
        s_nxt = s_r;
        // Two-flop synchronisers, then a delay stage for edges
        s_nxt.ext_s1 = {ext_pin_two_in, ext_pin_one_in, ext_pin_zero_in};
        s_nxt.ext_s2 = s_r.ext_s1;
        s_nxt.ext_d = s_r.ext_s2;
        s_nxt.p1_s1 = port1_pins_in;
        s_nxt.p1_s2 = s_r.p1_s1;
        s_nxt.p1_d = s_r.p1_s2;
        s_nxt.flags = s_r.flags & ~ack_clr;
        // Register writes
        if (reg_wr_in) begin
            if (reg_addr_in == ipm_pkg::ADDR_POWER) begin
                s_nxt.smod = reg_wdata_in[ipm_pkg::PWR_SMOD_BIT];
                s_nxt.gf1 = reg_wdata_in[ipm_pkg::PWR_GF1_BIT];
                s_nxt.gf0 = reg_wdata_in[ipm_pkg::PWR_GF0_BIT];
                if (reg_wdata_in[ipm_pkg::PWR_STOP_BIT] && !pin_low) begin
                    s_nxt.stop_request_bit = 1'b1;
                    s_nxt.mode = ipm_pkg::MODE_STOP;
                end else if (reg_wdata_in[ipm_pkg::PWR_IDLE_BIT]) begin
                    s_nxt.cpu_nap_request = 1'b1;
                    s_nxt.mode = ipm_pkg::MODE_IDLE;
                end
            end else if (reg_addr_in == ipm_pkg::ADDR_WAKE) begin
                s_nxt.wake = reg_wdata_in;
            end else if (reg_addr_in == ipm_pkg::ADDR_EN_MAIN) begin
                s_nxt.global_int_enable = reg_wdata_in[ipm_pkg::EN_GLOBAL_BIT];
                s_nxt.en_m = reg_wdata_in[5:0];
            end else if (reg_addr_in == ipm_pkg::ADDR_EN_SEC) begin
                s_nxt.en_s = reg_wdata_in[4:0];
            end else if (reg_addr_in == ipm_pkg::ADDR_PRIO_LO) begin
                s_nxt.pl = reg_wdata_in[5:0];
            end else if (reg_addr_in == ipm_pkg::ADDR_PRIO_HI) begin
                s_nxt.ph = reg_wdata_in[5:0];
            end else if (reg_addr_in == ipm_pkg::ADDR_PRIO2_LO) begin
                s_nxt.p2l = reg_wdata_in[4:0];
            end else if (reg_addr_in == ipm_pkg::ADDR_PRIO2_HI) begin
                s_nxt.p2h = reg_wdata_in[4:0];
            end else if (reg_addr_in == ipm_pkg::ADDR_FLAG_A) begin
                s_nxt.flags[7:0] = s_nxt.flags[7:0] & reg_wdata_in; // Write 0 clears
            end else if (reg_addr_in == ipm_pkg::ADDR_FLAG_B) begin
                s_nxt.flags[15:8] = s_nxt.flags[15:8] & reg_wdata_in;
            end
        end
        // Set after clear so a same-cycle event survives
        s_nxt.flags = s_nxt.flags | set_v;
        // Mode exits clear the request bits
        case (s_r.mode)
            ipm_pkg::MODE_IDLE: begin
                if (any_req) begin
                    s_nxt.mode = ipm_pkg::MODE_RUN;
                    s_nxt.cpu_nap_request = 1'b0;
                end
            end
            ipm_pkg::MODE_STOP: begin
                if (pin_wake) begin
                    s_nxt.mode = ipm_pkg::MODE_RUN;
                    s_nxt.stop_request_bit = 1'b0;
                    s_nxt.hold = STOP_RESUME_CYCLES;
                end
            end
            default: begin
                if (s_r.hold != 8'h00) s_nxt.hold = s_r.hold - 8'h01;
            end
        endcase
        // In-service levels: return pops the top, fetch pushes
        if (irq_return_in && active_top[2]) begin
            s_nxt.insvc[active_top[1:0]] = 1'b0;
        end
        if (irq_ack_in && s_r.req) s_nxt.insvc[s_r.lvl] = 1'b1;
        // Request held off after stop wake and while fetching
        s_nxt.req = grant && !irq_ack_in && s_r.hold == 8'h00
            && s_nxt.hold == 8'h00 && s_r.mode != ipm_pkg::MODE_STOP;
        if (grant) begin
            s_nxt.vec = vec_of(best_idx);
            s_nxt.lvl = best_lvl;
        end
        // Read data one cycle after the strobe
        s_nxt.rdata = ipm_pkg::REG_RESET;
        if (reg_rd_in) begin
            if (reg_addr_in == ipm_pkg::ADDR_POWER) begin
                s_nxt.rdata = {s_r.smod, 3'h0, s_r.gf1, s_r.gf0, s_r.stop_request_bit,
                    s_r.cpu_nap_request};
            end else if (reg_addr_in == ipm_pkg::ADDR_WAKE) begin
                s_nxt.rdata = s_r.wake;
            end else if (reg_addr_in == ipm_pkg::ADDR_EN_MAIN) begin
                s_nxt.rdata = {s_r.global_int_enable, 1'b0, s_r.en_m};
            end else if (reg_addr_in == ipm_pkg::ADDR_EN_SEC) begin
                s_nxt.rdata = {3'h0, s_r.en_s};
            end else if (reg_addr_in == ipm_pkg::ADDR_PRIO_LO) begin
                s_nxt.rdata = {2'h0, s_r.pl};
            end else if (reg_addr_in == ipm_pkg::ADDR_PRIO_HI) begin
                s_nxt.rdata = {2'h0, s_r.ph};
            end else if (reg_addr_in == ipm_pkg::ADDR_PRIO2_LO) begin
                s_nxt.rdata = {3'h0, s_r.p2l};
            end else if (reg_addr_in == ipm_pkg::ADDR_PRIO2_HI) begin
                s_nxt.rdata = {3'h0, s_r.p2h};
            end else if (reg_addr_in == ipm_pkg::ADDR_FLAG_A) begin
                s_nxt.rdata = s_r.flags[7:0];
            end else if (reg_addr_in == ipm_pkg::ADDR_FLAG_B) begin
                s_nxt.rdata = s_r.flags[15:8];
            end
        end
    end

    // State register; reset also ends idle and stop
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_r <= '0;
            s_r.ext_s1 <= ipm_pkg::PIN_IDLE;
            s_r.ext_s2 <= ipm_pkg::PIN_IDLE;
            s_r.ext_d <= ipm_pkg::PIN_IDLE;
            // Port chain tracks the pins so release shows no false change
            s_r.p1_s1 <= s_nxt.p1_s1;
            s_r.p1_s2 <= s_nxt.p1_s2;
            s_r.p1_d <= s_nxt.p1_d;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Request, vector, level, read data from flops; clock enables decoded from mode and inputs
    assign reg_rdata_out = s_r.rdata;
    assign irq_req_out = s_r.req;
    assign irq_vector_out = s_r.vec;
    assign irq_level_out = s_r.lvl;
    assign cpu_clk_en_out = s_r.mode == ipm_pkg::MODE_RUN;
    assign periph_clk_en_out = s_r.mode == ipm_pkg::MODE_RUN
        || (s_r.mode == ipm_pkg::MODE_IDLE && !idle_periph_clock_gate_in);
    assign sys_clk_en_out = s_r.mode != ipm_pkg::MODE_STOP;
    assign wdt_clk_en_out = s_r.mode != ipm_pkg::MODE_STOP || wdt_enable_in;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_idle_cpu_off: assert property (s_r.mode == ipm_pkg::MODE_IDLE
        |-> !cpu_clk_en_out && sys_clk_en_out) else $error("cpu clock runs in idle");
    a_idle_gate_periph: assert property (s_r.mode == ipm_pkg::MODE_IDLE
        |-> periph_clk_en_out == !idle_periph_clock_gate_in)
        else $error("idle peripheral gating wrong");
    a_idle_wake_exit: assert property (s_r.mode == ipm_pkg::MODE_IDLE && any_req
        |=> s_r.mode == ipm_pkg::MODE_RUN && !s_r.cpu_nap_request)
        else $error("idle not left on request");
    a_stop_clocks_off: assert property (s_r.mode == ipm_pkg::MODE_STOP
        |-> !sys_clk_en_out && wdt_clk_en_out == wdt_enable_in)
        else $error("clock runs in stop");
    a_stop_no_wake: assert property (s_r.mode == ipm_pkg::MODE_STOP && !pin_wake
        |=> s_r.mode == ipm_pkg::MODE_STOP) else $error("stop left without pin");
    a_stop_blocked: assert property (reg_wr_in && reg_addr_in == ipm_pkg::ADDR_POWER
        && pin_low && s_r.mode == ipm_pkg::MODE_RUN |=> s_r.mode != ipm_pkg::MODE_STOP)
        else $error("stop entered with pin low");
    a_flag_set_t0: assert property (periph_ev_in.timer0_overflow_flag
        |=> s_r.flags.timer0_overflow_flag) else $error("event flag lost");
    a_global_block: assert property (!$past(s_r.global_int_enable)
        |-> !irq_req_out) else $error("request with global enable off");
    a_vector_legal: assert property (irq_req_out
        |-> irq_vector_out[2:0] == 3'h3 && irq_vector_out <= 16'h005B
        && irq_vector_out != 16'h0033) else $error("illegal vector");
    a_nest_higher: assert property (irq_req_out && active_top[2]
        |-> irq_level_out > active_top[1:0]) else $error("request not above active level");
    a_stop_resume: assert property (s_r.mode == ipm_pkg::MODE_STOP
        ##1 s_r.mode == ipm_pkg::MODE_RUN |-> !irq_req_out [*4])
        else $error("request before resume instruction");

    c_idle_wake: cover property (s_r.mode == ipm_pkg::MODE_IDLE ##1 irq_req_out);
    c_stop_wake: cover property (s_r.mode == ipm_pkg::MODE_STOP
        ##1 s_r.mode == ipm_pkg::MODE_RUN);
    c_nested: cover property (s_r.insvc[0] && s_r.insvc[3]);
    c_stop_refused: cover property (reg_wr_in && reg_addr_in == ipm_pkg::ADDR_POWER
        && reg_wdata_in[ipm_pkg::PWR_STOP_BIT] && pin_low);
endmodule // ipm_ctrl

`default_nettype wire

// file: rtl/ipm_pkg.sv
// Package for the interrupt and power-mode controller: offsets, bits, types.
// Assumes an 8-bit special register port and one always-on system clock.
`default_nettype none

package ipm_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_POWER = 8'h87;
    localparam logic [7:0] ADDR_WAKE = 8'h96;
    localparam logic [7:0] ADDR_EN_MAIN = 8'hA8;
    localparam logic [7:0] ADDR_EN_SEC = 8'hA9;
    localparam logic [7:0] ADDR_PRIO_LO = 8'hB8;
    localparam logic [7:0] ADDR_PRIO_HI = 8'hB9;
    localparam logic [7:0] ADDR_PRIO2_LO = 8'hBA;
    localparam logic [7:0] ADDR_PRIO2_HI = 8'hBB;
    localparam logic [7:0] ADDR_FLAG_A = 8'hC0;
    localparam logic [7:0] ADDR_FLAG_B = 8'hC1;
    // Field positions
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_STOP_BIT = 1;
    localparam int PWR_GF0_BIT = 2;
    localparam int PWR_GF1_BIT = 3;
    localparam int PWR_SMOD_BIT = 7;
    localparam int EN_GLOBAL_BIT = 7;
    // Sources, in vector order
    localparam int NUM_SRC = 11;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_P1 = 7;
    localparam int SRC_EXT2 = 8;
    localparam int RESERVED_SLOT = 6;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    // Reset values and timing
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] PIN_IDLE = 3'h7;
    localparam logic [7:0] STOP_RESUME_CYCLES = 8'h04;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_IDLE = 2'b01,
        MODE_STOP = 2'b10
    } ipm_mode_t;

    typedef struct packed {
        logic spi_mode_fault_flag, spi_collision_flag, spi_done_flag;
        logic touch_done_flag, adc_done_flag, timer3_overflow_flag;
        logic timer2_external_flag, timer2_overflow_flag;
        logic uart_tx_flag, uart_rx_flag;
        logic timer1_overflow_flag, timer0_overflow_flag;
    } ipm_periph_ev_t;

    typedef struct packed {
        logic spi_mode_fault_flag, spi_collision_flag, spi_done_flag;
        logic touch_done_flag, adc_done_flag, ext2_edge_flag;
        logic port_change_flag, timer3_overflow_flag;
        logic timer2_external_flag, timer2_overflow_flag;
        logic uart_tx_flag, uart_rx_flag;
        logic timer1_overflow_flag, ext1_edge_flag;
        logic timer0_overflow_flag, ext0_edge_flag;
    } ipm_flags_t;

    typedef struct packed {
        ipm_mode_t mode;
        logic smod, gf1, gf0, cpu_nap_request, stop_request_bit, global_int_enable;
        logic [7:0] wake;
        logic [5:0] en_m, pl, ph;
        logic [4:0] en_s, p2l, p2h;
        ipm_flags_t flags;
        logic [3:0] insvc;
        logic req;
        logic [15:0] vec;
        logic [1:0] lvl;
        logic [7:0] hold, rdata;
        logic [2:0] ext_s1, ext_s2, ext_d;
        logic [7:0] p1_s1, p1_s2, p1_d;
    } ipm_state_t;
endpackage

`default_nettype wire

// file: tb/ipm_cpu_model.sv
// CPU model: takes each presented vector once, promptly or late.
// Assumes the controller's registered request on the same clock edge.
`default_nettype none

module ipm_cpu_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Controller side
    input wire logic irq_req_in,
    input wire logic [15:0] irq_vector_in,
    output logic irq_ack_out,
    output logic irq_return_out,
    // Bench control and record
    input wire logic [3:0] ack_delay_in,
    input wire logic ret_cmd_in,
    output logic [15:0] taken_vec_out,
    output logic [7:0] taken_cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_r;

    // Ack is one cycle, so the request still high after it is not taken twice
    always_ff @(posedge clk_in) begin
        irq_return_out <= ret_cmd_in;
        if (reset_in) begin
            taken_cnt_out <= 8'h00;
            taken_vec_out <= 16'h0000;
        end
        if (reset_in || !irq_req_in || irq_ack_out) begin
            irq_ack_out <= 1'b0;
            wait_r <= 4'h0;
        end else if (wait_r == ack_delay_in) begin
            irq_ack_out <= 1'b1;
            taken_vec_out <= irq_vector_in;
            taken_cnt_out <= taken_cnt_out + 8'h01;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule  // ipm_cpu_model

`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the interrupt and power-mode controller.
// Assumes ipm_pkg, ipm_ctrl and the CPU model are compiled first.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, reset_in = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ret_cmd = 1'b0;
    logic pin0 = 1'b1, gate = 1'b0, wdt_en = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, p1 = 8'h00, rdata, tcnt;
    logic [3:0] ack_dly = 4'h0;
    logic [11:0] ev = 12'h000;
    logic irq_req, ack, ret, cpu_en, per_en, sys_en, wdt_clk;
    logic [15:0] vec, taken;
    logic [1:0] lvl;
    int num_errors = 0, total_checks = 0;
    // Vector slot of each peripheral event bit, timer0 first
    logic [3:0] slot [12] = '{4'h1, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h7, 4'hA, 4'hA, 4'hB,
        4'hB, 4'hB};
    // Writable registers, flags last, and their readable bits
    logic [7:0] regs [9] = '{ipm_pkg::ADDR_WAKE, ipm_pkg::ADDR_EN_MAIN, ipm_pkg::ADDR_EN_SEC,
        ipm_pkg::ADDR_PRIO_LO, ipm_pkg::ADDR_PRIO_HI, ipm_pkg::ADDR_PRIO2_LO,
        ipm_pkg::ADDR_PRIO2_HI, ipm_pkg::ADDR_FLAG_A, ipm_pkg::ADDR_FLAG_B};
    logic [7:0] mask [9] = '{8'hFF, 8'hBF, 8'h1F, 8'h3F, 8'h3F, 8'h1F, 8'h1F, 8'h00, 8'h00};

    ipm_ctrl #(.STOP_RESUME_CYCLES(8'h04)) i_dut (
        .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .periph_ev_in(ipm_pkg::ipm_periph_ev_t'(ev)), .ext_pin_zero_in(pin0),
        .ext_pin_one_in(1'b1), .ext_pin_two_in(1'b1), .port1_pins_in(p1),
        .idle_periph_clock_gate_in(gate), .wdt_enable_in(wdt_en), .irq_ack_in(ack),
        .irq_return_in(ret), .irq_req_out(irq_req), .irq_vector_out(vec), .irq_level_out(lvl),
        .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en), .sys_clk_en_out(sys_en),
        .wdt_clk_en_out(wdt_clk));
    ipm_cpu_model i_cpu (
        .clk_in(clk_in), .reset_in(reset_in), .irq_req_in(irq_req), .irq_vector_in(vec),
        .irq_ack_out(ack), .irq_return_out(ret), .ack_delay_in(ack_dly),
        .ret_cmd_in(ret_cmd), .taken_vec_out(taken), .taken_cnt_out(tcnt));

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chkb(input string what, input logic exp, input logic seen);
        chk(what, {15'h0000, exp}, {15'h0000, seen});
    endtask

    // One-cycle strobes, changed just after the edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        #1 chk(what, {8'h00, exp}, {8'h00, rdata});
    endtask

    task automatic pulse(input logic [11:0] v);
        @(posedge clk_in);
        ev <= v;
        @(posedge clk_in);
        ev <= 12'h000;
    endtask

    // Bounded wait for the CPU model to take exactly one vector
    task automatic take(input logic [15:0] exp);
        logic [7:0] c0;
        c0 = tcnt;
        for (int i = 0; i < 40 && tcnt == c0; i++) @(posedge clk_in);
        #1 chk("take count", {8'h00, c0 + 8'h01}, {8'h00, tcnt});
        chk("vector", exp, taken);
    endtask

    task automatic retn();
        @(posedge clk_in);
        ret_cmd <= 1'b1;
        @(posedge clk_in);
        ret_cmd <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Tests take a few hundred cycles; this span is far beyond that
    initial begin
        #300000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        // Reset values, reserved bits, write-one on flags, unmapped place
        for (int i = 0; i < 9; i++) rchk("reset", regs[i], 8'h00);
        for (int i = 0; i < 9; i++) begin
            wr(regs[i], 8'hFF);
            rchk("readback", regs[i], mask[i]);
            wr(regs[i], 8'h00);
        end
        wr(8'h90, 8'hFF);
        rchk("unmapped", 8'h90, 8'h00);
        wr(ipm_pkg::ADDR_POWER, 8'h8C);
        rchk("power", ipm_pkg::ADDR_POWER, 8'h8C);
        wr(ipm_pkg::ADDR_POWER, 8'h00);
        // Flag set whatever the enables; serviced only when both allow
        wr(ipm_pkg::ADDR_EN_MAIN, 8'h80);
        pulse(12'h001);
        repeat (4) @(posedge clk_in);
        #1 chkb("src off", 1'b0, irq_req);
        rchk("flag", ipm_pkg::ADDR_FLAG_A, 8'h02);
        wr(ipm_pkg::ADDR_EN_MAIN, 8'h3A);
        repeat (4) @(posedge clk_in);
        #1 chkb("global off", 1'b0, irq_req);
        wr(ipm_pkg::ADDR_EN_MAIN, 8'hBA);
        take(16'h000B);
        wr(ipm_pkg::ADDR_FLAG_A, 8'h00);
        retn();
        // Every peripheral event alone, acked promptly and late in turn
        wr(ipm_pkg::ADDR_EN_SEC, 8'h19);
        for (int b = 0; b < 12; b++) begin
            ack_dly <= b[0] ? 4'h3 : 4'h0;
            pulse(12'h001 << b);
            take(ipm_pkg::VEC_BASE + ipm_pkg::VEC_STEP * {12'h000, slot[b]});
            wr(ipm_pkg::ADDR_FLAG_A, 8'h00);
            wr(ipm_pkg::ADDR_FLAG_B, 8'h00);
            retn();
        end
        ack_dly <= 4'h0;
        // Tie goes to the lower vector; level 3 preempts, equal level waits
        pulse(12'h005);
        take(16'h000B);
        wr(ipm_pkg::ADDR_FLAG_A, 8'hFD);
        retn();
        take(16'h0023);
        wr(ipm_pkg::ADDR_PRIO_LO, 8'h08);
        wr(ipm_pkg::ADDR_PRIO_HI, 8'h08);
        pulse(12'h001);
        repeat (6) @(posedge clk_in);
        #1 chkb("equal held", 1'b0, irq_req);
        pulse(12'h002);
        take(16'h001B);
        chk("level", 16'h0003, {14'h0000, lvl});
        wr(ipm_pkg::ADDR_FLAG_A, 8'hE7);
        retn();
        repeat (4) @(posedge clk_in);
        #1 chkb("resumed held", 1'b0, irq_req);
        retn();
        take(16'h000B);
        wr(ipm_pkg::ADDR_FLAG_A, 8'h00);
        retn();
        // Pin flags clear themselves when the vector is taken
        wr(ipm_pkg::ADDR_EN_MAIN, 8'h81);
        wr(ipm_pkg::ADDR_EN_SEC, 8'h02);
        wr(ipm_pkg::ADDR_WAKE, 8'h01);
        @(posedge clk_in) pin0 <= 1'b0;
        take(16'h0003);
        rchk("edge flag", ipm_pkg::ADDR_FLAG_A, 8'h00);
        retn();
        @(posedge clk_in) p1 <= 8'h01;
        take(16'h0043);
        rchk("change flag", ipm_pkg::ADDR_FLAG_B, 8'h00);
        retn();
        // Stop refused while the enabled pin is low, left only by a pin
        wr(ipm_pkg::ADDR_EN_MAIN, 8'h01);
        wr(ipm_pkg::ADDR_POWER, 8'h02);
        rchk("stop refused", ipm_pkg::ADDR_POWER, 8'h00);
        chkb("sys clk", 1'b1, sys_en);
        @(posedge clk_in) pin0 <= 1'b1;
        repeat (4) @(posedge clk_in);
        wr(ipm_pkg::ADDR_POWER, 8'h02);
        repeat (2) @(posedge clk_in);
        #1 chkb("stop cpu", 1'b0, cpu_en);
        chkb("stop sys", 1'b0, sys_en);
        chkb("stop wdt off", 1'b0, wdt_clk);
        @(posedge clk_in) wdt_en <= 1'b1;
        pulse(12'h001);
        repeat (4) @(posedge clk_in);
        #1 chkb("stop wdt on", 1'b1, wdt_clk);
        chkb("timer wake", 1'b0, sys_en);
        @(posedge clk_in) pin0 <= 1'b0;
        for (int i = 0; i < 10 && sys_en !== 1'b1; i++) @(posedge clk_in);
        #1 chkb("pin wake", 1'b1, sys_en);
        repeat (8) @(posedge clk_in);
        #1 chkb("no entry", 1'b0, irq_req);
        rchk("stop bit", ipm_pkg::ADDR_POWER, 8'h00);
        wr(ipm_pkg::ADDR_FLAG_A, 8'h00);
        // Idle: cpu sleeps, peripherals gated only on request
        @(posedge clk_in) pin0 <= 1'b1;
        @(posedge clk_in) gate <= 1'b1;
        wr(ipm_pkg::ADDR_EN_MAIN, 8'h82);
        wr(ipm_pkg::ADDR_POWER, 8'h01);
        repeat (2) @(posedge clk_in);
        #1 chkb("idle cpu", 1'b0, cpu_en);
        chkb("idle gated", 1'b0, per_en);
        chkb("idle sys", 1'b1, sys_en);
        @(posedge clk_in) gate <= 1'b0;
        #1 chkb("idle periph", 1'b1, per_en);
        pulse(12'h001);
        take(16'h000B);
        chkb("woken cpu", 1'b1, cpu_en);
        rchk("idle bit", ipm_pkg::ADDR_POWER, 8'h00);
        tally_and_finish();
    end
endmodule  // testbench

`default_nettype wire
